// File: codec_map.svh
`ifndef CODEC_MAP_SVH
`define CODEC_MAP_SVH

// Running disparity loaded on reset (negative).
`define RD_RESET      1'b0

// Forcing codes, y field 7 in bits 7 to 5, xx field 1 or 2 in bits 4 to 0.
`define C17_CODE      8'hE1
`define C27_CODE      8'hE2

// Forced characters: the comma character in its negative and positive variants.
`define C17_CHAR      10'h0FA
`define C27_CHAR      10'h305

// Special six-bit group and its xx value.
`define K28_X         5'h1C
`define K28_SIX_NEG   6'h0F

// Alternate four-bit group for y field 7.
`define ALT4_NEG      4'h7
`define ALT4_POS      4'h8

// Balanced groups that still force an ending disparity.
`define SIX_POS_PAT   6'h07
`define SIX_NEG_PAT   6'h38
`define FOUR_POS_PAT  4'h3
`define FOUR_NEG_PAT  4'hC

`endif

// File: codec_pkg.sv
package codec_pkg;

	typedef enum logic {
		RD_NEG = 1'b0,
		RD_POS = 1'b1
	} rd_t;

	// Parallel byte with its special character indicator.
	typedef struct packed {
		logic       special_char_flag;
		logic [7:0] data;
	} codec_byte_t;

	// Ten-bit character; bit 9 is a and goes onto the line first.
	typedef struct packed {
		logic [5:0] abcdei;
		logic [3:0] fghj;
	} char_t;

endpackage : codec_pkg

// File: disparity_step.sv
`timescale 1ns/1ns
`include "codec_map.svh"

module disparity_step (
	input  wire codec_pkg::rd_t rd_in,   // Disparity before the character.
	input  wire logic [5:0]     six,     // Group abcdei.
	input  wire logic [3:0]     four,    // Group fghj.
	output codec_pkg::rd_t      rd_mid,  // Disparity after the six-bit group.
	output codec_pkg::rd_t      rd_out   // Disparity after the character.
);

	always_comb begin
		if ($countones(six) > 3 || six == `SIX_POS_PAT) begin
			rd_mid = codec_pkg::RD_POS;
		end else if ($countones(six) < 3 || six == `SIX_NEG_PAT) begin
			rd_mid = codec_pkg::RD_NEG;
		end else begin
			rd_mid = rd_in;
		end
		if ($countones(four) > 2 || four == `FOUR_POS_PAT) begin
			rd_out = codec_pkg::RD_POS;
		end else if ($countones(four) < 2 || four == `FOUR_NEG_PAT) begin
			rd_out = codec_pkg::RD_NEG;
		end else begin
			rd_out = rd_mid;
		end
	end

endmodule : disparity_step

// File: eight_ten_bit_disparity_codec.sv
// Functional notes
// - Bit i leaves the serializer right after bit e and before bit f.
// - Characters go out and come in as a, b, c, d, e, i, f, g, h, j.
// - Disparity is one binary state that picks one of two variants per code.
// - The encoder starts with negative disparity after reset.
// - The encoder sends the variant for its disparity, then updates it.
// - Two forcing codes send one special character in a fixed variant.
// - The decoder starts with negative disparity after reset and checks every character.
// - Disparity runs through the six-bit group, then the four-bit group.
// - A group ends positive on more ones, or on 000111 or 0011.
// - A group ends negative on more zeros, or on 111000 or 1100.
// - Otherwise a group ends with the disparity it started with.
// - A received character is looked up in both columns but checked only against its current column.
// - Disparity is updated from every received character, valid or not.
// - Bits 7 to 5 hold the y field and bits 4 to 0 the xx field.
// - Violations are judged against the decoder's own tracked disparity.
// - The special flag is high for special and low for data characters.
`timescale 1ns/1ns
`include "codec_map.svh"

module eight_ten_bit_disparity_codec (
	input  wire logic                  clk,           // 125 MHz byte clock.
	input  wire logic                  resetn,        // Synchronous reset, active low.
	input  wire logic                  tx_valid,      // Byte to encode this cycle.
	input  wire codec_pkg::codec_byte_t tx_byte,      // Byte and special flag.
	output codec_pkg::char_t           tx_char,       // Encoded character, a in bit 9.
	output logic                       tx_char_valid, // Character valid pulse.
	output codec_pkg::rd_t             tx_rd,         // Encoder disparity.
	input  wire logic                  rx_valid,      // Character to decode this cycle.
	input  wire codec_pkg::char_t      rx_char,       // Received character, a in bit 9.
	output codec_pkg::codec_byte_t     rx_byte,       // Decoded byte and special flag.
	output logic                       rx_violation,  // Code violation for rx_byte.
	output logic                       rx_byte_valid, // Decoded byte valid pulse.
	output codec_pkg::rd_t             rx_rd          // Decoder disparity.
);

	localparam logic [5:0] SIX_TAB [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] FOUR_TAB [8] = '{
		4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	// ********************************************************************
	// Character encode and decode functions
	// ********************************************************************

	function automatic codec_pkg::char_t encode(input codec_pkg::codec_byte_t b,
			input logic rd);
		logic [4:0]       x;
		logic [2:0]       y;
		logic             k28;
		logic             rdm;
		logic             alt;
		codec_pkg::char_t c;
		// y field high, xx field low
		x   = b.data[4:0];
		y   = b.data[7:5];
		k28 = b.special_char_flag && x == `K28_X;
		c.abcdei = k28 ? `K28_SIX_NEG : SIX_TAB[x];
		if (rd && ($countones(c.abcdei) != 3 || c.abcdei == `SIX_NEG_PAT)) begin
			c.abcdei = ~c.abcdei;
		end
		rdm = ($countones(c.abcdei) != 3) ? ~rd : rd;
		alt = y == 3'h7 && (k28 || (b.special_char_flag
			&& (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E))
			|| (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14))
			|| (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E)));
		c.fghj = alt ? `ALT4_NEG : FOUR_TAB[y];
		if (rdm && ($countones(c.fghj) != 2 || c.fghj == `FOUR_NEG_PAT)) begin
			c.fghj = ~c.fghj;
		end else if (k28 && !rdm && $countones(c.fghj) == 2
				&& c.fghj != `FOUR_NEG_PAT) begin
			c.fghj = ~c.fghj;
		end
		if (b.special_char_flag && b.data == `C17_CODE) begin
			c = `C17_CHAR;
		end else if (b.special_char_flag && b.data == `C27_CODE) begin
			c = `C27_CHAR;
		end
		return c;
	endfunction : encode

	// Finds the only byte whose groups can form this character.
	function automatic codec_pkg::codec_byte_t decode(input codec_pkg::char_t c);
		logic [4:0]             x;
		logic [2:0]             y;
		logic [3:0]             f;
		logic                   alt;
		codec_pkg::codec_byte_t b;
		x = 5'h00;
		y = 3'h0;
		f = c.fghj;
		// A balanced group other than 111000 stands unchanged in both columns, so its complement
		// belongs to another code and must not match it.
		for (int i = 0; i < 32; i++) begin
			if (c.abcdei == SIX_TAB[i]
					|| (c.abcdei == ~SIX_TAB[i] && ($countones(SIX_TAB[i]) != 3
					|| SIX_TAB[i] == `SIX_NEG_PAT))) begin
				x = 5'(i);
			end
		end
		// The positive special six-bit group flips a balanced four-bit group.
		if (c.abcdei == ~`K28_SIX_NEG && $countones(f) == 2 && f != `FOUR_POS_PAT
				&& f != `FOUR_NEG_PAT) begin
			f = ~f;
		end
		for (int j = 0; j < 8; j++) begin
			if (f == FOUR_TAB[j]
					|| (f == ~FOUR_TAB[j] && ($countones(FOUR_TAB[j]) != 2
					|| FOUR_TAB[j] == `FOUR_NEG_PAT))) begin
				y = 3'(j);
			end
		end
		alt = f == `ALT4_NEG || f == `ALT4_POS;
		if (alt) begin
			y = 3'h7;
		end
		b.special_char_flag = 1'b0;
		if (c.abcdei == `K28_SIX_NEG || c.abcdei == ~`K28_SIX_NEG) begin
			x = `K28_X;
			b.special_char_flag = 1'b1;
		end else if (alt && (x == 5'h17 || x == 5'h1B || x == 5'h1D || x == 5'h1E)) begin
			b.special_char_flag = 1'b1;
		end
		b.data = {y, x};
		return b;
	endfunction : decode

	// ********************************************************************
	// Encoder
	// ********************************************************************

	codec_pkg::rd_t         tx_rd_ff;
	codec_pkg::rd_t         nxt_tx_rd;
	codec_pkg::rd_t         tx_rd_new;
	codec_pkg::char_t       tx_char_ff;
	codec_pkg::char_t       nxt_tx_char;
	codec_pkg::char_t       tx_enc;
	logic                   tx_char_valid_ff;
	logic                   nxt_tx_char_valid;

	assign tx_enc = encode(tx_byte, tx_rd_ff);

	disparity_step u_tx_step (
		.rd_in  (tx_rd_ff),
		.six    (tx_enc.abcdei),
		.four   (tx_enc.fghj),
		.rd_mid (),
		.rd_out (tx_rd_new)
	);

	always_comb begin
		nxt_tx_rd         = tx_rd_ff;
		nxt_tx_char       = tx_char_ff;
		nxt_tx_char_valid = tx_valid;
		if (tx_valid) begin
			nxt_tx_rd = tx_rd_new;
			// i placed between e and f
			nxt_tx_char = tx_enc;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			tx_rd_ff         <= codec_pkg::rd_t'(`RD_RESET);
			tx_char_ff       <= '0;
			tx_char_valid_ff <= 1'b0;
		end else begin
			tx_rd_ff         <= nxt_tx_rd;
			tx_char_ff       <= nxt_tx_char;
			tx_char_valid_ff <= nxt_tx_char_valid;
		end
	end

	assign tx_char       = tx_char_ff;
	assign tx_char_valid = tx_char_valid_ff;
	assign tx_rd         = tx_rd_ff;

	// ********************************************************************
	// Decoder
	// ********************************************************************

	codec_pkg::rd_t         rx_rd_ff;
	codec_pkg::rd_t         nxt_rx_rd;
	codec_pkg::rd_t         rx_rd_new;
	codec_pkg::codec_byte_t rx_byte_ff;
	codec_pkg::codec_byte_t nxt_rx_byte;
	codec_pkg::codec_byte_t rx_dec;
	logic                   rx_viol_ff;
	logic                   nxt_rx_viol;
	logic                   rx_byte_valid_ff;
	logic                   nxt_rx_byte_valid;

	assign rx_dec = decode(rx_char);

	disparity_step u_rx_step (
		.rd_in  (rx_rd_ff),
		.six    (rx_char.abcdei),
		.four   (rx_char.fghj),
		.rd_mid (),
		.rd_out (rx_rd_new)
	);

	always_comb begin
		nxt_rx_rd         = rx_rd_ff;
		nxt_rx_byte       = rx_byte_ff;
		nxt_rx_viol       = rx_viol_ff;
		nxt_rx_byte_valid = rx_valid;
		if (rx_valid) begin
			nxt_rx_byte = rx_dec;
			// match only in the current column
			nxt_rx_viol = encode(rx_dec, rx_rd_ff) != rx_char;
			nxt_rx_rd = rx_rd_new;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			rx_rd_ff         <= codec_pkg::rd_t'(`RD_RESET);
			rx_byte_ff       <= '0;
			rx_viol_ff       <= 1'b0;
			rx_byte_valid_ff <= 1'b0;
		end else begin
			rx_rd_ff         <= nxt_rx_rd;
			rx_byte_ff       <= nxt_rx_byte;
			rx_viol_ff       <= nxt_rx_viol;
			rx_byte_valid_ff <= nxt_rx_byte_valid;
		end
	end

	assign rx_byte       = rx_byte_ff;
	assign rx_violation  = rx_viol_ff;
	assign rx_byte_valid = rx_byte_valid_ff;
	assign rx_rd         = rx_rd_ff;

	// ********************************************************************
	// Checks
	// ********************************************************************

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_c17_in;
		tx_valid && tx_byte.special_char_flag && tx_byte.data == `C17_CODE;
	endsequence

	sequence s_c27_in;
		tx_valid && tx_byte.special_char_flag && tx_byte.data == `C27_CODE;
	endsequence

	a_tx_char_timing: assert property ((tx_valid |=> tx_char_valid)
			and (!tx_valid |=> !tx_char_valid))
		else $error("Encoded character not one cycle after its byte.");
	a_tx_rd_hold: assert property (!tx_valid |=> tx_rd == $past(tx_rd))
		else $error("Encoder disparity moved without a byte.");
	a_tx_forced_neg: assert property (s_c17_in |=> tx_char == `C17_CHAR)
		else $error("First forcing code sent the wrong character.");
	a_tx_forced_pos: assert property (s_c27_in |=> tx_char == `C27_CHAR)
		else $error("Second forcing code sent the wrong character.");
	a_tx_decodes_back: assert property (tx_valid && !(tx_byte.special_char_flag
			&& (tx_byte.data == `C17_CODE || tx_byte.data == `C27_CODE))
			|=> encode(decode(tx_char), $past(tx_rd)) == tx_char)
		else $error("Encoder produced a character outside its column.");
	a_rx_flag_align: assert property (rx_valid |=> rx_byte_valid && rx_byte == $past(rx_dec))
		else $error("Decoded byte not aligned with its character.");
	a_rx_four_pos: assert property (rx_valid && rx_char.fghj == `FOUR_POS_PAT |=> rx_rd == codec_pkg::RD_POS)
		else $error("Pattern 0011 did not leave disparity positive.");
	a_rx_four_neg: assert property (rx_valid && rx_char.fghj == `FOUR_NEG_PAT |=> rx_rd == codec_pkg::RD_NEG)
		else $error("Pattern 1100 did not leave disparity negative.");
	a_rx_rd_balanced: assert property (rx_valid && $countones(rx_char.abcdei) == 3
			&& rx_char.abcdei != `SIX_POS_PAT && rx_char.abcdei != `SIX_NEG_PAT
			&& $countones(rx_char.fghj) == 2 && rx_char.fghj != `FOUR_POS_PAT
			&& rx_char.fghj != `FOUR_NEG_PAT |=> rx_rd == $past(rx_rd))
		else $error("Neutral character changed decoder disparity.");
	a_rx_rd_hold: assert property (!rx_valid |=> $stable(rx_rd))
		else $error("Decoder disparity moved without a character.");

endmodule : eight_ten_bit_disparity_codec

// File: eight_ten_bit_disparity_codec_bench.sv
`timescale 1ns/1ns

// ****************************************
// Loopback through the link model.
// ****************************************
module eight_ten_bit_disparity_codec_bench;
	logic                   clk;
	logic                   resetn;
	logic                   tx_valid;
	logic                   tx_char_valid;
	logic                   rx_valid;
	logic                   rx_violation;
	logic                   rx_byte_valid;
	logic [9:0]             err_mask;
	codec_pkg::codec_byte_t tx_byte;
	codec_pkg::codec_byte_t rx_byte;
	codec_pkg::char_t       tx_char;
	codec_pkg::char_t       rx_char;
	codec_pkg::rd_t         tx_rd;
	codec_pkg::rd_t         rx_rd;
	int                     n_fail;
	int                     checks;

	eight_ten_bit_disparity_codec dut (
		.clk(clk), .resetn(resetn), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.tx_char(tx_char), .tx_char_valid(tx_char_valid), .tx_rd(tx_rd),
		.rx_valid(rx_valid), .rx_char(rx_char), .rx_byte(rx_byte),
		.rx_violation(rx_violation), .rx_byte_valid(rx_byte_valid), .rx_rd(rx_rd)
	);

	link_model link (
		.clk(clk), .char_valid(tx_char_valid), .char_in(tx_char),
		.err_mask(err_mask), .out_valid(rx_valid), .char_out(rx_char)
	);

	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task tally_and_finish;
		$display("mismatches %0d comparisons %0d", n_fail, checks);
		if (n_fail == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish

	// Encodes one byte, checks the character, then checks its decode.
	task automatic send(input logic k, input logic [7:0] d, input logic [9:0] err,
		input logic [9:0] ech, input logic erd, input logic [7:0] edat,
		input logic ev, input logic errd);
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_byte  <= '{k, d};
		err_mask <= err;
		@(posedge clk);
		tx_valid <= 1'b0;
		#1;
		chk(tx_char_valid, 1'b1);
		chk(tx_char, ech);
		chk(tx_rd, erd);
		@(posedge clk);
		err_mask <= 10'h000;
		@(posedge clk);
		#1;
		chk(rx_byte_valid, 1'b1);
		chk(rx_violation, ev);
		chk(rx_rd, errd);
		if (!ev) begin
			chk(rx_byte.special_char_flag, k);
		end
		if (!ev && !k) begin
			chk(rx_byte.data, edat);
		end
	endtask : send

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#5000;
		n_fail++;
		tally_and_finish();
	end

	initial begin
		n_fail   = 0;
		checks   = 0;
		resetn   = 1'b0;
		tx_valid = 1'b0;
		tx_byte  = '0;
		err_mask = 10'h000;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		#1;
		chk(tx_rd, 1'b0);
		chk(rx_rd, 1'b0);
		chk(tx_char_valid, 1'b0);
		send(0, 8'h35, 10'h002, 10'h2A9, 0, 8'h15, 0, 1);
		send(0, 8'h4A, 10'h000, 10'h155, 0, 8'h4A, 0, 1);
		send(0, 8'hB7, 10'h000, 10'h3AA, 1, 8'h00, 1, 1);
		send(0, 8'h67, 10'h000, 10'h073, 1, 8'h67, 0, 1);
		send(0, 8'h07, 10'h000, 10'h074, 0, 8'h07, 0, 0);
		send(0, 8'h67, 10'h000, 10'h38C, 0, 8'h67, 0, 0);
		send(0, 8'h07, 10'h000, 10'h38B, 1, 8'h07, 0, 1);
		send(0, 8'h45, 10'h000, 10'h295, 1, 8'h45, 0, 1);
		send(1, 8'hE1, 10'h000, 10'h0FA, 1, 8'h00, 1, 1);
		send(1, 8'hE2, 10'h000, 10'h305, 0, 8'h00, 0, 0);
		send(1, 8'hE2, 10'h000, 10'h305, 0, 8'h00, 1, 0);
		send(1, 8'hE1, 10'h000, 10'h0FA, 1, 8'h00, 0, 1);
		send(1, 8'hFC, 10'h000, 10'h307, 1, 8'hFC, 0, 1);
		tally_and_finish();
	end
endmodule : eight_ten_bit_disparity_codec_bench

// File: link_model.sv
`timescale 1ns/1ns

// ****************************************
// Serial link between encoder and decoder.
// ****************************************
module link_model (
	input  wire logic             clk,        // Byte clock.
	input  wire logic             char_valid, // Character from the encoder.
	input  wire codec_pkg::char_t char_in,    // Character, a in bit 9.
	input  wire logic [9:0]       err_mask,   // Bits flipped on the wire.
	output logic                  out_valid,  // Character for the decoder.
	output codec_pkg::char_t      char_out    // Received character.
);
	logic [9:0] wire_bits;

	always_comb begin
		for (int n = 0; n < 10; n++) begin
			wire_bits[n] = char_in[9 - n] ^ err_mask[9 - n];
		end
	end

	// Between characters the released line shows the inverse of the last value.
	always_ff @(posedge clk) begin
		out_valid <= char_valid;
		if (char_valid) begin
			for (int n = 0; n < 10; n++) begin
				char_out[9 - n] <= wire_bits[n];
			end
		end else begin
			char_out <= ~char_out;
		end
	end
endmodule : link_model
